// File: host_model.sv
// Host model: APB master that configures and services the block
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_pready,
	input  wire logic        i_pslverr,
	input  wire logic [31:0] i_prdata,
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic [11:0]      o_paddr,
	output logic [31:0]      o_pwdata
);
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 12'h000;
		o_pwdata = 32'h0;
	end
	// One transfer; ok stays low when no answer comes within the bound
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err, output logic ok);
		int n;
		@(posedge i_core_clk);
		o_psel <= 1'b1;
		o_penable <= 1'b0;
		o_pwrite <= wr;
		o_paddr <= a;
		o_pwdata <= wd;
		@(posedge i_core_clk);
		o_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_core_clk);
			n++;
		end while (i_pready !== 1'b1 && n < 20);
		// Source registers are read here, which is what clears latched flags
		rd = i_prdata;
		err = i_pslverr;
		ok = (i_pready === 1'b1);
		o_psel <= 1'b0;
		o_penable <= 1'b0;
	endtask : xfer
endmodule : host_model
`default_nettype wire

// File: motion_event_detect_wake_ctrl.sv
// Event detection, auto wake/sleep and interrupt pin routing with APB registers
//
// Operation
// - Auto sleep: drop to sleep rate after inactivity timeout expires.
// - Only tap, orientation, motion/freefall, transient events wake the device.
// - Buffer gate holds buffer contents over sleep; buffer never wakes.
// - Wake events and buffer interrupt hold off the inactivity timeout.
// - One detector configurable as freefall (below) or motion (above).
// - Freefall flags when magnitude on enabled axes stays below threshold.
// - Motion has selectable high-pass; freefall always uses unfiltered data.
// - Motion/freefall asserted only after debounce count of samples.
// - Motion source records triggering axes and direction per axis.
// - High-pass cutoff has four settings, scaled by output sample rate.
// - Transient uses filtered data, threshold, debounce; filter bypass option.
// - Transient routing bit 5 of pin routing register picks the pin.
// - Transient config, threshold, debounce, source are four consecutive registers.
// - Transient source reports sign of change per triggering axis.
// - Single/double tap with pulse width, latency timers, per-axis thresholds.
// - Tap input selectable through high-pass and optionally low-pass filter.
// - Tap source updates with axes and polarity of the tap.
// - Orientation resolves six positions with trip midpoint and hysteresis.
// - Orientation frozen below Z-lockout angle; reset 29, minimum 14 degrees.
// - Seven interrupt sources, each enabled and routable to either pin.
// - Enabled source flag set asserts its selected interrupt pin.
`include "motion_event_params.svh"
`timescale 1ns/1ps
`default_nettype none

module motion_event_detect_wake_ctrl #(
	parameter int AW = 12
) (
	input  wire logic                    i_core_clk,
	input  wire logic                    i_resetn,
	input  wire logic                    i_ce,
	input  wire logic                    i_psel,
	input  wire logic                    i_penable,
	input  wire logic                    i_pwrite,
	input  wire logic [AW-1:0]           i_paddr,
	input  wire logic [31:0]             i_pwdata,
	output logic                         o_pready,
	output logic                         o_pslverr,
	output logic [31:0]                  o_prdata,
	input  wire logic                    i_sample_valid,
	input  wire motion_event_pkg::accel_s i_sample,
	input  wire logic                    i_buf_event,
	output logic                         o_sleep_rate,
	output logic                         o_buf_hold,
	output logic                         o_event_pin_one,
	output logic                         o_event_pin_two
);
	if (AW < 8) begin : g_aw_check
		$error("AW too small for register map");
	end

	// Register file
	logic [7:0]  ctrl_r, buf_gate_r, int_en_r, event_pin_routing_reg_r, sleep_tmo_r;
	logic [7:0]  mf_cfg_r, mf_ths_r, mf_cnt_r, mf_src_r;
	logic [7:0]  tr_cfg_r, tr_ths_r, tr_cnt_r, tr_src_r;
	logic [7:0]  tap_cfg_r, tap_src_r, tap_lim_r, tap_lat_r;
	logic [23:0] tap_ths_r;
	logic [7:0]  ori_mid_r, ori_src_r;
	logic [2:0]  ori_hys_r, ori_zlock_r;
	logic [1:0]  hpf_sel_r;
	logic [7:0]  int_src_r;
	motion_event_pkg::pwr_e pwr_r;

	logic wr_en, rd_en;
	assign wr_en = i_ce && i_psel && i_penable && i_pwrite;
	assign rd_en = i_ce && i_psel && i_penable && !i_pwrite;
	assign o_pready = 1'b1;

	logic mapped;
	always_comb begin
		case (i_paddr)
			`REG_CTRL, `REG_BUF_GATE, `REG_INT_EN, `REG_INT_ROUTE, `REG_INT_SRC, `REG_SLEEP_TMO,
			`REG_MF_CFG, `REG_MF_SRC, `REG_TR_CFG, `REG_TR_THS, `REG_TR_CNT, `REG_TR_SRC,
			`REG_TAP_CFG, `REG_TAP_THS, `REG_TAP_TMR, `REG_TAP_SRC, `REG_ORI_CFG,
			`REG_ORI_SRC, `REG_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign o_pslverr = i_psel && i_penable && !mapped;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_r <= 8'h00; buf_gate_r <= 8'h00; int_en_r <= 8'h00;
			event_pin_routing_reg_r <= 8'h00; sleep_tmo_r <= `SLEEP_TMO_RST;
			mf_cfg_r <= 8'h00; mf_ths_r <= 8'h00; mf_cnt_r <= 8'h00;
			tr_cfg_r <= 8'h00; tr_ths_r <= 8'h00; tr_cnt_r <= 8'h00;
			tap_cfg_r <= 8'h00; tap_ths_r <= 24'h000000; tap_lim_r <= 8'h00; tap_lat_r <= 8'h00;
			ori_mid_r <= `MID_RST; ori_hys_r <= `HYST_RST; ori_zlock_r <= `ZLOCK_RST;
			hpf_sel_r <= 2'h0;
		end else if (wr_en) begin
			case (i_paddr)
				`REG_CTRL:      {hpf_sel_r, ctrl_r} <= {i_pwdata[9:8], i_pwdata[7:0]};
				`REG_BUF_GATE:  buf_gate_r <= i_pwdata[7:0];
				`REG_INT_EN:    int_en_r <= i_pwdata[7:0];
				`REG_INT_ROUTE: event_pin_routing_reg_r <= i_pwdata[7:0];
				`REG_SLEEP_TMO: sleep_tmo_r <= i_pwdata[7:0];
				`REG_MF_CFG:    {mf_cnt_r, mf_ths_r, mf_cfg_r} <= i_pwdata[23:0];
				`REG_TR_CFG:    tr_cfg_r <= i_pwdata[7:0];
				`REG_TR_THS:    tr_ths_r <= i_pwdata[7:0];
				`REG_TR_CNT:    tr_cnt_r <= i_pwdata[7:0];
				`REG_TAP_CFG:   tap_cfg_r <= i_pwdata[7:0];
				`REG_TAP_THS:   tap_ths_r <= i_pwdata[23:0];
				`REG_TAP_TMR:   {tap_lat_r, tap_lim_r} <= i_pwdata[15:0];
				`REG_ORI_CFG: begin
					ori_mid_r <= i_pwdata[7:0];
					ori_hys_r <= i_pwdata[10:8];
					// Lockout code 0 maps to the 14 degree floor, 4 to the 29 degree default
					ori_zlock_r <= (i_pwdata[14:12] < `ZLOCK_MIN) ? `ZLOCK_MIN : i_pwdata[14:12];
				end
				default: ;
			endcase
		end
	end

	// Source register reads clear the matching latched flag
	logic rd_int_src, rd_mf, rd_tr, rd_tap, rd_ori;
	assign rd_int_src = rd_en && i_paddr == `REG_INT_SRC;
	assign rd_mf      = rd_en && i_paddr == `REG_MF_SRC;
	assign rd_tr      = rd_en && i_paddr == `REG_TR_SRC;
	assign rd_tap     = rd_en && i_paddr == `REG_TAP_SRC;
	assign rd_ori     = rd_en && i_paddr == `REG_ORI_SRC;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_prdata <= 32'h0;
		end else if (i_ce && i_psel && !i_penable) begin
			case (i_paddr)
				`REG_CTRL:      o_prdata <= {22'h0, hpf_sel_r, ctrl_r};
				`REG_BUF_GATE:  o_prdata <= {24'h0, buf_gate_r};
				`REG_INT_EN:    o_prdata <= {24'h0, int_en_r};
				`REG_INT_ROUTE: o_prdata <= {24'h0, event_pin_routing_reg_r};
				`REG_INT_SRC:   o_prdata <= {24'h0, int_src_r};
				`REG_SLEEP_TMO: o_prdata <= {24'h0, sleep_tmo_r};
				`REG_MF_CFG:    o_prdata <= {8'h0, mf_cnt_r, mf_ths_r, mf_cfg_r};
				`REG_MF_SRC:    o_prdata <= {24'h0, mf_src_r};
				`REG_TR_CFG:    o_prdata <= {24'h0, tr_cfg_r};
				`REG_TR_THS:    o_prdata <= {24'h0, tr_ths_r};
				`REG_TR_CNT:    o_prdata <= {24'h0, tr_cnt_r};
				`REG_TR_SRC:    o_prdata <= {24'h0, tr_src_r};
				`REG_TAP_CFG:   o_prdata <= {24'h0, tap_cfg_r};
				`REG_TAP_THS:   o_prdata <= {8'h0, tap_ths_r};
				`REG_TAP_TMR:   o_prdata <= {16'h0, tap_lat_r, tap_lim_r};
				`REG_TAP_SRC:   o_prdata <= {24'h0, tap_src_r};
				`REG_ORI_CFG:   o_prdata <= {17'h0, ori_zlock_r, 1'b0, ori_hys_r, ori_mid_r};
				`REG_ORI_SRC:   o_prdata <= {24'h0, ori_src_r};
				`REG_STATUS:    o_prdata <= {31'h0, pwr_r == motion_event_pkg::PWR_SLEEP};
				default:        o_prdata <= 32'h0;
			endcase
		end
	end

	// High-pass filter: first order, shift set by cutoff select; shift is one less in sleep, doubling cutoff per sample
	logic signed [19:0] hp_acc [3];
	logic signed [13:0] raw [3];
	logic signed [13:0] hp [3];
	logic [2:0] hp_shift;
	assign raw[0] = i_sample.x;
	assign raw[1] = i_sample.y;
	assign raw[2] = i_sample.z;
	assign hp_shift = 3'(hpf_sel_r) + 3'h2 + (pwr_r == motion_event_pkg::PWR_SLEEP ? 3'h0 : 3'h1);

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int a = 0; a < 3; a++) hp_acc[a] <= 20'sh0;
		end else if (i_ce && i_sample_valid) begin
			for (int a = 0; a < 3; a++)
				hp_acc[a] <= hp_acc[a] + (((20'(raw[a]) <<< 6) - hp_acc[a]) >>> hp_shift);
		end
	end
	always_comb begin
		for (int a = 0; a < 3; a++) hp[a] = 14'(raw[a] - 14'(hp_acc[a] >>> 6));
	end

	function automatic logic [12:0] mag(input logic signed [13:0] v);
		mag = v[13] ? 13'(-v) : v[12:0];
	endfunction

	// Motion / freefall detector
	logic [2:0] mf_ax, mf_dir, tr_ax, tr_dir;
	logic       mf_cond, tr_cond;
	logic [7:0] mf_deb, tr_deb;
	always_comb begin
		mf_ax = 3'h0;
		mf_dir = 3'h0;
		tr_ax = 3'h0;
		tr_dir = 3'h0;
		for (int a = 0; a < 3; a++) begin
			// Freefall ignores the filter select
			logic signed [13:0] v;
			logic signed [13:0] t;
			v = (mf_cfg_r[`MF_MOTION] && mf_cfg_r[`MF_HPF]) ? hp[a] : raw[a];
			mf_ax[a] = mf_cfg_r[`MF_MOTION] ? (mag(v) > {mf_ths_r, 5'h0}) : (mag(v) < {mf_ths_r, 5'h0});
			mf_dir[a] = v[13];
			t = tr_cfg_r[`TR_BYPASS] ? raw[a] : hp[a];
			tr_ax[a] = mag(t) > {tr_ths_r, 5'h0};
			tr_dir[a] = t[13];
		end
		mf_ax = mf_ax & mf_cfg_r[5:3];
		tr_ax = tr_ax & tr_cfg_r[3:1];
		// Freefall needs all enabled axes low, motion any one high
		mf_cond = mf_cfg_r[`MF_MOTION] ? |mf_ax : (mf_cfg_r[5:3] != 3'h0 && mf_ax == mf_cfg_r[5:3]);
		tr_cond = |tr_ax;
	end

	logic mf_hit, tr_hit, tap_hit, ori_hit;
	assign mf_hit = i_sample_valid && mf_cond && mf_deb == mf_cnt_r;
	assign tr_hit = i_sample_valid && tr_cond && tr_deb == tr_cnt_r;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			mf_deb <= 8'h0;
			tr_deb <= 8'h0;
		end else if (i_ce && i_sample_valid) begin
			mf_deb <= !mf_cond ? 8'h0 : (mf_deb == mf_cnt_r ? mf_deb : mf_deb + 8'h1);
			tr_deb <= !tr_cond ? 8'h0 : (tr_deb == tr_cnt_r ? tr_deb : tr_deb + 8'h1);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			mf_src_r <= 8'h0;
			tr_src_r <= 8'h0;
		end else if (i_ce) begin
			if (mf_hit) mf_src_r <= {1'b1, 1'b0, mf_ax, mf_dir};
			else if (rd_mf) mf_src_r <= 8'h0;
			if (tr_hit) tr_src_r <= {1'b1, 1'b0, tr_ax, tr_dir};
			else if (rd_tr) tr_src_r <= 8'h0;
		end
	end

	// Tap detector: pulse above threshold must fall within width limit
	motion_event_pkg::tap_e tap_st;
	logic signed [13:0] tap_in [3];
	logic signed [13:0] lp [3];
	logic [2:0] tap_ax, tap_pol, seen_ax, seen_pol;
	logic [7:0] tap_tmr;
	logic       tap_single;
	always_comb begin
		tap_ax = 3'h0;
		tap_pol = 3'h0;
		for (int a = 0; a < 3; a++) begin
			tap_in[a] = tap_cfg_r[`TAP_HPF] ? (tap_cfg_r[`TAP_LPF] ? lp[a] : hp[a]) : raw[a];
			tap_ax[a] = tap_cfg_r[2+a] && mag(tap_in[a]) > {tap_ths_r[a*8 +: 8], 5'h0};
			tap_pol[a] = tap_in[a][13];
		end
	end
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int a = 0; a < 3; a++) lp[a] <= 14'sh0;
		end else if (i_ce && i_sample_valid) begin
			for (int a = 0; a < 3; a++) lp[a] <= 14'((15'(lp[a]) + 15'(hp[a])) >>> 1);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tap_st <= motion_event_pkg::TAP_IDLE;
			tap_tmr <= 8'h0;
			tap_src_r <= 8'h0;
			tap_single <= 1'b0;
			{seen_ax, seen_pol} <= 6'h0;
		end else if (i_ce) begin
			tap_single <= 1'b0;
			if (rd_tap) tap_src_r <= 8'h0;
			if (i_sample_valid) begin
				tap_tmr <= tap_tmr + 8'h1;
				case (tap_st)
					motion_event_pkg::TAP_IDLE: if (|tap_ax) begin
						// Axes and polarity are kept from the pulse start, the quiet sample has none
						{seen_ax, seen_pol} <= {tap_ax, tap_pol};
						tap_st <= motion_event_pkg::TAP_PULSE;
						tap_tmr <= 8'h0;
					end
					motion_event_pkg::TAP_PULSE: begin
						if (tap_tmr >= tap_lim_r) tap_st <= motion_event_pkg::TAP_IDLE;
						else if (!(|tap_ax)) begin
							tap_src_r <= {1'b1, 1'b0, seen_ax, seen_pol};
							tap_single <= 1'b1;
							tap_st <= motion_event_pkg::TAP_LAT;
							tap_tmr <= 8'h0;
						end
					end
					motion_event_pkg::TAP_LAT: if (tap_tmr >= tap_lat_r) begin
						tap_st <= motion_event_pkg::TAP_WIN;
						tap_tmr <= 8'h0;
					end
					motion_event_pkg::TAP_WIN: begin
						if (|tap_ax) begin
							tap_src_r <= {1'b1, 1'b1, tap_ax, tap_pol};  // Double tap
							tap_single <= 1'b1;
							tap_st <= motion_event_pkg::TAP_IDLE;
						end else if (tap_tmr >= tap_lat_r) tap_st <= motion_event_pkg::TAP_IDLE;
					end
					default: tap_st <= motion_event_pkg::TAP_IDLE;
				endcase
			end
		end
	end
	assign tap_hit = tap_single;

	// Orientation: portrait/landscape by dominant axis with hysteresis; back/front by Z sign
	logic [2:0] ori_pos;
	logic [12:0] zlock_lim, trip_hi, trip_lo;
	logic [2:0] ori_new;
	always_comb begin
		// Z lockout: while |Z| is at or above the lockout limit the orientation is held unchanged
		zlock_lim = 13'({ori_zlock_r, 9'h0}) + 13'h0800;
		trip_hi = 13'({ori_mid_r, 5'h0}) + 13'({ori_hys_r, 6'h0});
		trip_lo = 13'({ori_mid_r, 5'h0}) - 13'({ori_hys_r, 6'h0});
		ori_new = ori_pos;
		if (mag(raw[0]) > trip_hi && mag(raw[0]) > mag(raw[1]))
			ori_new = {1'b0, raw[0][13], 1'b0};                                     // Landscape
		else if (mag(raw[1]) > trip_hi && mag(raw[1]) > mag(raw[0]))
			ori_new = {1'b0, raw[1][13], 1'b1};                                     // Portrait
		else if (mag(raw[0]) < trip_lo && mag(raw[1]) < trip_lo)
			ori_new = {1'b1, raw[2][13], ori_pos[0]};                               // Face up/down
	end
	assign ori_hit = i_sample_valid && mag(raw[2]) < zlock_lim && ori_new != ori_pos;
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ori_pos <= 3'h0;
			ori_src_r <= 8'h0;
		end else if (i_ce) begin
			if (ori_hit) begin
				ori_pos <= ori_new;
				ori_src_r <= {1'b1, 4'h0, ori_new};
			end else if (rd_ori) ori_src_r <= {1'b0, ori_src_r[6:0]};
		end
	end

	// Power state with inactivity timer
	logic [7:0] idle_cnt;
	logic       wake_ev, keep_ev, sleep_ev;
	assign wake_ev = (mf_hit && int_en_r[`SRC_MF]) || (tap_hit && int_en_r[`SRC_TAP]) ||
		(ori_hit && int_en_r[`SRC_ORI]) || (tr_hit && int_en_r[`SRC_TR]);
	assign keep_ev = wake_ev || (i_buf_event && int_en_r[`SRC_BUF]);
	assign sleep_ev = ctrl_r[`CTRL_ASLP_EN] && pwr_r == motion_event_pkg::PWR_WAKE &&
		!keep_ev && i_sample_valid && idle_cnt >= sleep_tmo_r;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pwr_r <= motion_event_pkg::PWR_WAKE;
			idle_cnt <= 8'h0;
		end else if (i_ce) begin
			if (!ctrl_r[`CTRL_ASLP_EN]) begin
				pwr_r <= motion_event_pkg::PWR_WAKE;
				idle_cnt <= 8'h0;
			end else if (keep_ev) begin
				idle_cnt <= 8'h0;
				if (wake_ev) pwr_r <= motion_event_pkg::PWR_WAKE;
			end else if (sleep_ev) begin
				pwr_r <= motion_event_pkg::PWR_SLEEP;
				idle_cnt <= 8'h0;
			end else if (i_sample_valid && pwr_r == motion_event_pkg::PWR_WAKE) begin
				idle_cnt <= idle_cnt + 8'h1;
			end
		end
	end
	assign o_sleep_rate = pwr_r == motion_event_pkg::PWR_SLEEP;
	assign o_buf_hold = buf_gate_r[0] && o_sleep_rate;

	// Interrupt sources: set wins over read clear
	logic [7:0] src_set;
	always_comb begin
		src_set = 8'h0;
		src_set[`SRC_DRDY]  = i_sample_valid;
		src_set[`SRC_MF]    = mf_hit;
		src_set[`SRC_TAP]   = tap_hit;
		src_set[`SRC_ORI]   = ori_hit;
		src_set[`SRC_TR]    = tr_hit;
		src_set[`SRC_BUF]   = i_buf_event;
		src_set[`SRC_SLEEP] = sleep_ev || (wake_ev && o_sleep_rate);
	end
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			int_src_r <= 8'h0;
		end else if (i_ce) begin
			int_src_r <= (src_set & int_en_r) |
				(int_src_r & ~({rd_int_src, rd_int_src, rd_tr, rd_ori, rd_tap, rd_mf, 1'b0, rd_int_src}));
		end
	end
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_event_pin_one <= 1'b0;
			o_event_pin_two <= 1'b0;
		end else if (i_ce) begin
			// Routing bit set sends a source to pin one, clear to pin two
			o_event_pin_one <= |(int_src_r & int_en_r & event_pin_routing_reg_r);
			o_event_pin_two <= |(int_src_r & int_en_r & ~event_pin_routing_reg_r);
		end
	end
endmodule : motion_event_detect_wake_ctrl
`default_nettype wire

// File: motion_event_detect_wake_ctrl_test.sv
// Self-checking bench for the motion event block
`timescale 1ns/1ps
`default_nettype none
`include "motion_event_params.svh"
module motion_event_detect_wake_ctrl_test;
	logic                     i_core_clk = 1'b0;
	logic                     i_resetn = 1'b0;
	logic                     psel, penable, pwrite, pready, pslverr, sleep_rate, buf_hold, pin_one, pin_two;
	logic                     smp_valid = 1'b0;
	logic                     buf_ev = 1'b0;
	logic [11:0]              paddr;
	logic [31:0]              pwdata, prdata;
	motion_event_pkg::accel_s smp = '0;
	int                       mismatches = 0;
	int                       n_compared = 0;
	always #5 i_core_clk = ~i_core_clk;
	motion_event_detect_wake_ctrl #(.AW(12)) motion_event_detect_wake_ctrl_inst (.i_core_clk(i_core_clk),
		.i_resetn(i_resetn), .i_ce(1'b1), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata), .i_sample_valid(smp_valid),
		.i_sample(smp), .i_buf_event(buf_ev), .o_sleep_rate(sleep_rate), .o_buf_hold(buf_hold),
		.o_event_pin_one(pin_one), .o_event_pin_two(pin_two));
	host_model host_model_inst (.i_core_clk(i_core_clk), .i_pready(pready), .i_pslverr(pslverr), .i_prdata(prdata),
		.o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, seen);
			mismatches++;
		end
	endtask : check
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic e, input logic wr = 1'b0,
		input logic [31:0] wd = 32'h0);
		logic ok;
		host_model_inst.xfer(wr, a, wd, d, e, ok);
		if (!ok) begin
			mismatches++;
			complete_run();
		end
	endtask : rd
	task automatic wr(input logic [11:0] a, input logic [31:0] wd);
		logic [31:0] d;
		logic e;
		rd(a, d, e, 1'b1, wd);
	endtask : wr
	task automatic send(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z, input int n);
		repeat (n) begin
			@(posedge i_core_clk);
			smp_valid <= 1'b1;
			smp <= {x, y, z};
			@(posedge i_core_clk);
			smp_valid <= 1'b0;
			repeat (4) @(posedge i_core_clk);
		end
	endtask : send
	task automatic pulse_buf;
		@(posedge i_core_clk);
		buf_ev <= 1'b1;
		@(posedge i_core_clk);
		buf_ev <= 1'b0;
	endtask : pulse_buf
	task automatic test_reset;
		logic [31:0] d;
		logic e;
		rd(`REG_SLEEP_TMO, d, e);
		check("sleep_tmo", d, {24'h0, `SLEEP_TMO_RST});
		rd(`REG_ORI_CFG, d, e);
		check("ori_cfg", d, {17'h0, `ZLOCK_RST, 1'b0, `HYST_RST, `MID_RST});
		wr(`REG_ORI_CFG, {17'h0, `ZLOCK_MIN, 1'b0, `HYST_RST, `MID_RST});
		rd(`REG_ORI_CFG, d, e);
		check("zlock_min", d, {17'h0, `ZLOCK_MIN, 1'b0, `HYST_RST, `MID_RST});
		rd(12'h0fc, d, e);
		check("unmapped", d, 32'h0);
		check("unmapped_err", e, 1'b1);
		check("idle_outs", {pin_one, pin_two, sleep_rate}, 3'b000);
		$display("test_reset done");
	endtask : test_reset
	task automatic test_mf;
		logic [31:0] d;
		logic e;
		wr(`REG_INT_ROUTE, 32'h04);
		wr(`REG_INT_EN, 32'h04);
		wr(`REG_MF_CFG, 32'h0003_1039);
		send(14'h0fa0, 14'h0, 14'h0, 1);
		rd(`REG_INT_SRC, d, e);
		check("mf_early", d[`SRC_MF], 1'b0);
		send(14'h0fa0, 14'h0, 14'h0, 4);
		rd(`REG_INT_SRC, d, e);
		check("motion", d[`SRC_MF], 1'b1);
		check("mf_pins", {pin_one, pin_two}, 2'b10);
		rd(`REG_MF_SRC, d, e);
		check("mf_axes", d != 0, 1'b1);
		repeat (3) @(posedge i_core_clk);
		check("mf_clear", {pin_one, pin_two}, 2'b00);
		wr(`REG_INT_ROUTE, 32'h00);
		wr(`REG_MF_CFG, 32'h0002_103a);
		send(14'h0fa0, 14'h0fa0, 14'h0fa0, 20);
		rd(`REG_INT_SRC, d, e);
		check("ff_unfiltered", d[`SRC_MF], 1'b0);
		send(14'h0, 14'h0, 14'h0, 4);
		rd(`REG_INT_SRC, d, e);
		check("freefall", d[`SRC_MF], 1'b1);
		check("ff_pins", {pin_one, pin_two}, 2'b01);
		rd(`REG_MF_SRC, d, e);
		$display("test_mf done");
	endtask : test_mf
	task automatic test_transient;
		logic [31:0] d;
		logic e;
		wr(`REG_INT_EN, 32'h20);
		wr(`REG_TR_CFG, 32'h0f);
		wr(`REG_TR_THS, 32'h10);
		wr(`REG_TR_CNT, 32'h01);
		rd(`REG_TR_THS, d, e);
		check("tr_ths", d, 32'h10);
		for (int r = 0; r < 2; r++) begin
			wr(`REG_INT_ROUTE, 32'(r) << 5);
			send(14'h0fa0, 14'h0, 14'h0, 3);
			check("tr_pins", {pin_one, pin_two}, (r == 1) ? 2'b10 : 2'b01);
			rd(`REG_TR_SRC, d, e);
			check("tr_src", d != 0, 1'b1);
			repeat (3) @(posedge i_core_clk);
			check("tr_clear", {pin_one, pin_two}, 2'b00);
		end
		$display("test_transient done");
	endtask : test_transient
	task automatic test_tap;
		logic [31:0] d;
		logic e;
		wr(`REG_INT_EN, 32'h08);
		wr(`REG_INT_ROUTE, 32'h08);
		wr(`REG_TAP_THS, 32'h10);
		wr(`REG_TAP_TMR, 32'h0204);
		wr(`REG_TAP_CFG, 32'h04);
		send(14'h0fa0, 14'h0, 14'h0, 1);
		send(14'h0, 14'h0, 14'h0, 1);
		check("tap_pin", {pin_one, pin_two}, 2'b10);
		rd(`REG_TAP_SRC, d, e);
		check("single_tap", d, 32'h88);
		send(14'h0, 14'h0, 14'h0, 3);
		rd(`REG_ORI_SRC, d, e);
		check("face_up", d, 32'h84);
		send(14'h0fa0, 14'h0, 14'h0, 1);
		rd(`REG_TAP_SRC, d, e);
		check("double_tap", d, 32'hc8);
		rd(`REG_ORI_SRC, d, e);
		check("landscape", d, 32'h80);
		$display("test_tap done");
	endtask : test_tap
	task automatic test_sleep;
		logic [31:0] d;
		logic e;
		wr(`REG_INT_EN, 32'h00);
		wr(`REG_INT_ROUTE, 32'h01);
		wr(`REG_SLEEP_TMO, 32'h03);
		wr(`REG_BUF_GATE, 32'h01);
		wr(`REG_CTRL, 32'h01);
		send(14'h0, 14'h0, 14'h0, 3);
		check("awake", sleep_rate, 1'b0);
		send(14'h0, 14'h0, 14'h0, 2);
		check("asleep", {sleep_rate, buf_hold}, 2'b11);
		rd(`REG_STATUS, d, e);
		check("status", d[0], 1'b1);
		wr(`REG_INT_EN, 32'h41);
		pulse_buf();
		send(14'h0, 14'h0, 14'h0, 2);
		check("no_wake", sleep_rate, 1'b1);
		check("drdy_pin", {pin_one, pin_two}, 2'b11);
		wr(`REG_INT_EN, 32'h20);
		send(14'h0fa0, 14'h0, 14'h0, 2);
		check("woken", {sleep_rate, buf_hold}, 2'b00);
		rd(`REG_TR_SRC, d, e);
		wr(`REG_INT_EN, 32'h40);
		send(14'h0, 14'h0, 14'h0, 3);
		pulse_buf();
		send(14'h0, 14'h0, 14'h0, 3);
		check("held", sleep_rate, 1'b0);
		send(14'h0, 14'h0, 14'h0, 3);
		check("slept", sleep_rate, 1'b1);
		$display("test_sleep done");
	endtask : test_sleep
	initial begin
		repeat (6) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		test_reset();
		test_mf();
		test_transient();
		test_tap();
		test_sleep();
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge i_core_clk);
		mismatches++;
		complete_run();
	end
endmodule : motion_event_detect_wake_ctrl_test
`default_nettype wire

// File: motion_event_params.svh
// Constants for the motion event detection and wake control block
`ifndef MOTION_EVENT_PARAMS_SVH
`define MOTION_EVENT_PARAMS_SVH

// APB register byte offsets
`define REG_CTRL        12'h000
`define REG_BUF_GATE    12'h004
`define REG_INT_EN      12'h008
`define REG_INT_ROUTE   12'h00c
`define REG_INT_SRC     12'h010
`define REG_SLEEP_TMO   12'h014
`define REG_MF_CFG      12'h018
`define REG_MF_SRC      12'h01c
`define REG_TR_CFG      12'h020
`define REG_TR_THS      12'h024
`define REG_TR_CNT      12'h028
`define REG_TR_SRC      12'h02c
`define REG_TAP_CFG     12'h030
`define REG_TAP_THS     12'h034
`define REG_TAP_TMR     12'h038
`define REG_TAP_SRC     12'h03c
`define REG_ORI_CFG     12'h040
`define REG_ORI_SRC     12'h044
`define REG_STATUS      12'h048

// Interrupt source bit positions
`define SRC_DRDY   0
`define SRC_MF     2
`define SRC_TAP    3
`define SRC_ORI    4
`define SRC_TR     5
`define SRC_BUF    6
`define SRC_SLEEP  7

// Control bits
`define CTRL_ASLP_EN 0
`define MF_MOTION    0
`define MF_HPF       1
`define TR_BYPASS    0
`define TAP_HPF      0
`define TAP_LPF      1

// Reset values and lockout minimum
`define SLEEP_TMO_RST  8'h10
`define ZLOCK_RST      3'h4
`define ZLOCK_MIN      3'h0
`define HYST_RST       3'h2
`define MID_RST        8'h20

`endif

// File: motion_event_pkg.sv
// Types shared by the motion event detection block
package motion_event_pkg;
	typedef enum logic {PWR_WAKE, PWR_SLEEP} pwr_e;
	typedef enum logic [1:0] {TAP_IDLE, TAP_PULSE, TAP_LAT, TAP_WIN} tap_e;
	typedef struct packed {
		logic signed [13:0] x;
		logic signed [13:0] y;
		logic signed [13:0] z;
	} accel_s;
endpackage : motion_event_pkg

// File: motion_event_props.sv
// Port-level assertions for the motion event block
`timescale 1ns/1ps
`default_nettype none
module motion_event_props #(
	parameter int AW = 12
) (
	input wire logic                     i_core_clk,
	input wire logic                     i_resetn,
	input wire logic                     i_ce,
	input wire logic                     i_psel,
	input wire logic                     i_penable,
	input wire logic                     i_pwrite,
	input wire logic [AW-1:0]            i_paddr,
	input wire logic [31:0]              i_pwdata,
	input wire logic                     o_pready,
	input wire logic                     o_pslverr,
	input wire logic [31:0]              o_prdata,
	input wire logic                     i_sample_valid,
	input wire motion_event_pkg::accel_s i_sample,
	input wire logic                     i_buf_event,
	input wire logic                     o_sleep_rate,
	input wire logic                     o_buf_hold,
	input wire logic                     o_event_pin_one,
	input wire logic                     o_event_pin_two
);
	logic acc;
	assign acc = i_psel && i_penable;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	chk_ready_always: assert property (o_pready) else $error("pready low");
	chk_err_in_access: assert property (o_pslverr |-> acc) else $error("pslverr outside access");
	chk_unmapped_zero: assert property (acc && !i_pwrite && o_pslverr |-> o_prdata == 32'h0)
		else $error("unmapped read data not zero");
	chk_hold_asleep: assert property (o_buf_hold |-> o_sleep_rate) else $error("hold while awake");
	chk_hold_cause: assert property ($rose(o_buf_hold) |-> $rose(o_sleep_rate) || $past(acc && i_pwrite))
		else $error("hold rose without cause");
	chk_sleep_on_sample: assert property ($rose(o_sleep_rate) |-> $past(i_sample_valid) || $past(i_sample_valid, 2))
		else $error("sleep entry off sample");
	chk_wake_cause: assert property ($fell(o_sleep_rate) |->
		$past(i_sample_valid) || $past(i_sample_valid, 2) || $past(acc && i_pwrite)) else $error("wake without cause");
	chk_pin_one_held: assert property ($fell(o_event_pin_one) |-> $past(acc) || $past(acc, 2))
		else $error("pin one dropped without access");
	chk_pin_two_held: assert property ($fell(o_event_pin_two) |-> $past(acc) || $past(acc, 2))
		else $error("pin two dropped without access");
endmodule : motion_event_props
bind motion_event_detect_wake_ctrl motion_event_props #(.AW(AW)) motion_event_props_inst (.i_core_clk, .i_resetn,
	.i_ce, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .o_prdata, .i_sample_valid,
	.i_sample, .i_buf_event, .o_sleep_rate, .o_buf_hold, .o_event_pin_one, .o_event_pin_two);
`default_nettype wire
